/* core/kwu_keypad_wake.sv */
// Keypad wake unit: eight-pin falling-edge / low-level keypad request latch
// with mask, pending flag, write-one acknowledge and vector-fetch acknowledge.
// Assumes pins arrive asynchronously, while the vector fetch and the break
// signals come from CPU logic on the same clock.
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Each of the eight pins has its own wake enable bit.
// - Enabling a pin also switches on its pullup.
// - Latch a request when enabled pins go low after all were high.
// - Edge-only mode: no new latch while another enabled pin is low.
// - Edge-and-level mode: request stays while any enabled pin is low.
// - Mode set: clear only after acknowledge and all pins high, any order.
// - Fetch of the keypad vector acknowledges like a software write.
// - Writing one to the acknowledge strobe clears; it reads zero.
// - A falling edge after an acknowledge latches a new request.
// - Unmasked latched request raises a CPU interrupt using the keypad vector.
// - Mode clear: edge only, acknowledge clears at once.
// - Reset clears the request and the sensitivity select.
// - Pending flag shows the latch regardless of mask; reset clears it.
// - Mask bit one blocks the CPU interrupt; reset clears it.
// - Sensitivity select one: edges and levels; zero: edges only.
// - Wake enable forces the pin to input, overriding direction.
// - Reset clears all eight pin enables.
// - Active in wait and stop; unmasked request wakes the part.
// - In break an acknowledge write needs the clear permission.
module kwu_keypad_wake #(
  parameter int PIN_COUNT = 8
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [3:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Keypad pins and pad control
  input wire logic [PIN_COUNT-1:0] wake_pins_in,
  output kwu_pkg::kwu_pin_ctrl_t pin_ctrl_out,
  // CPU and system integration side
  input wire logic vector_fetch_in,
  input wire logic [15:0] vector_addr_in,
  input wire logic break_state_in,
  input wire logic break_clear_permission_in,
  output logic irq_out,
  output logic wake_out
);

  logic [PIN_COUNT-1:0] pin_meta;
  logic [PIN_COUNT-1:0] pin_sync;
  logic [PIN_COUNT-1:0] pin_wake_enables;
  logic request_mask;
  logic sensitivity_select;
  logic req_latched;
  logic ack_seen;
  logic prev_low_any;
  logic irq_q;
  logic low_any;
  logic edge_det;
  logic sw_ack_wr;
  logic fetch_ack;
  logic ack_now;
  logic next_req_latched;
  logic next_ack_seen;
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic wr_status;
  logic wr_enables;
  logic [7:0] status_view;

  // Two-stage synchroniser on every pin; only pin_sync is looked at
  generate
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_sync
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          pin_meta[i] <= 1'b1;
          pin_sync[i] <= 1'b1;
        end else begin
          pin_meta[i] <= wake_pins_in[i];
          pin_sync[i] <= pin_meta[i];
        end
      end
    end
  endgenerate

  // Enabled pins only; a disabled pin never counts as low
  assign low_any = |(pin_wake_enables & ~pin_sync);
  // Some enabled pin low now, none low the cycle before
  assign edge_det = low_any & ~prev_low_any;

  // Pullup and forced input both follow the enable; the forced input overrides
  // the pad's direction bit, so the pin reads as an input whatever that bit says
  assign pin_ctrl_out.pullup_en = pin_wake_enables;
  assign pin_ctrl_out.force_input = pin_wake_enables;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_low_any <= 1'b0;
    end else begin
      prev_low_any <= low_any;
    end
  end

  // Acknowledge sources: gated write, or fetch of the keypad vector
  assign sw_ack_wr = wr_status && w_strb[0] && w_data[kwu_pkg::ACK_BIT];
  assign fetch_ack = vector_fetch_in && (vector_addr_in == kwu_pkg::VECTOR_ADDR);
  assign ack_now = fetch_ack || (sw_ack_wr && (!break_state_in || break_clear_permission_in));

  // Request latch; a new edge wins over any acknowledge in the same cycle
  always_comb begin
    next_req_latched = req_latched;
    next_ack_seen = ack_seen;
    if (edge_det) begin
      next_req_latched = 1'b1;
      next_ack_seen = 1'b0;
    end else if (!sensitivity_select) begin
      if (ack_now) begin
        next_req_latched = 1'b0;
      end
      next_ack_seen = 1'b0;
    end else if (req_latched) begin
      // Level mode: both the acknowledge and all pins high are needed
      if ((ack_now || ack_seen) && !low_any) begin
        next_req_latched = 1'b0;
        next_ack_seen = 1'b0;
      end else if (ack_now) begin
        next_ack_seen = 1'b1;
      end
    end else begin
      next_ack_seen = 1'b0;
    end
  end

  // Reset drops the latch even with a pin held low
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_latched <= 1'b0;
      ack_seen <= 1'b0;
    end else begin
      req_latched <= next_req_latched;
      ack_seen <= next_ack_seen;
    end
  end

  // CPU request; stays live in wait and stop since nothing here is gated
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= req_latched && !request_mask;
    end
  end
  assign irq_out = irq_q;
  assign wake_out = irq_q;

  // Write address and data are taken independently, in either order
  assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
  assign s_axi_wready_out = !w_held && !s_axi_bvalid_out;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid_out;
  assign wr_status = wr_fire && (aw_addr[3:2] == kwu_pkg::STATUS_CTRL_OFS[3:2]);
  assign wr_enables = wr_fire && (aw_addr[3:2] == kwu_pkg::PIN_ENABLES_OFS[3:2]);

  // Address half waits here for the data half; while held it refuses another
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr_in;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  // Data half waits for the address half; its byte strobes travel with it
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      w_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata_in;
      w_strb <= s_axi_wstrb_in;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // Write response; unmapped addresses answer SLVERR and change nothing
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= kwu_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out <= (wr_status || wr_enables) ? kwu_pkg::RESP_OKAY : kwu_pkg::RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // Control bits; only byte lane 0 carries register data
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      request_mask <= kwu_pkg::MASK_RST;
      sensitivity_select <= kwu_pkg::MODE_RST;
    end else if (wr_status && w_strb[0]) begin
      request_mask <= w_data[kwu_pkg::MASK_BIT];
      sensitivity_select <= w_data[kwu_pkg::MODE_BIT];
    end
  end

  // Pin enables; enabling a pin that is already low gives a false request,
  // which software clears with the masked start-up sequence
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_wake_enables <= kwu_pkg::PIN_ENABLES_RST;
    end else if (wr_enables && w_strb[0]) begin
      pin_wake_enables <= w_data[PIN_COUNT-1:0];
    end
  end

  // Acknowledge bit is never stored, so it reads zero
  always_comb begin
    status_view = 8'h00;
    status_view[kwu_pkg::FLAG_BIT] = req_latched;
    status_view[kwu_pkg::MASK_BIT] = request_mask;
    status_view[kwu_pkg::MODE_BIT] = sensitivity_select;
  end

  // Read channel: one read at a time, data registered
  assign s_axi_arready_out = !s_axi_rvalid_out;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0;
      s_axi_rresp_out <= kwu_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out <= kwu_pkg::RESP_OKAY;
      if (s_axi_araddr_in[3:2] == kwu_pkg::STATUS_CTRL_OFS[3:2]) begin
        s_axi_rdata_out <= {24'h0, status_view};
      end else if (s_axi_araddr_in[3:2] == kwu_pkg::PIN_ENABLES_OFS[3:2]) begin
        s_axi_rdata_out <= {{(32-PIN_COUNT){1'b0}}, pin_wake_enables};
      end else begin
        s_axi_rdata_out <= 32'h0;
        s_axi_rresp_out <= kwu_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  // Checks on the request latch and its acknowledge paths
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  edge_latch_a: assert property (edge_det |=> req_latched)
    else $error("edge did not latch a request");
  edge_block_a: assert property (
    (!sensitivity_select && !req_latched && prev_low_any) |=> !req_latched)
    else $error("request latched while another pin was low");
  level_hold_a: assert property (
    (sensitivity_select && req_latched && low_any) |=> req_latched)
    else $error("level request dropped while a pin is low");
  level_clear_a: assert property (
    (sensitivity_select && req_latched && ack_now && !edge_det) ##1
    (!low_any && !edge_det) |=> !req_latched)
    else $error("level request not cleared after ack and release");
  edge_clear_a: assert property (
    (!sensitivity_select && ack_now && !edge_det) |=> !req_latched)
    else $error("edge-mode ack did not clear");
  fetch_ack_a: assert property (
    (vector_fetch_in && vector_addr_in == kwu_pkg::VECTOR_ADDR) |-> ack_now)
    else $error("vector fetch did not acknowledge");
  break_guard_a: assert property (
    (break_state_in && !break_clear_permission_in && !vector_fetch_in) |-> !ack_now)
    else $error("ack acted in break without permission");
  irq_raise_a: assert property (
    (req_latched && !request_mask) |=> irq_out)
    else $error("unmasked request gave no interrupt");
  mask_block_a: assert property (
    irq_out |-> !$past(request_mask))
    else $error("masked request reached the CPU");
  ack_read_a: assert property (
    (s_axi_arvalid_in && s_axi_arready_out &&
     s_axi_araddr_in[3:2] == kwu_pkg::STATUS_CTRL_OFS[3:2])
    |=> !s_axi_rdata_out[kwu_pkg::ACK_BIT] &&
    s_axi_rdata_out[kwu_pkg::FLAG_BIT] == $past(req_latched))
    else $error("status read wrong");

  // Further checks on the pin path, the mask and the two clear modes
  sync_path_a: assert property (
    pin_sync == $past(pin_meta))
    else $error("pin seen without passing both sync stages");
  pullup_follow_a: assert property (
    pin_ctrl_out.pullup_en == pin_wake_enables && pin_ctrl_out.force_input == pin_wake_enables)
    else $error("pad control does not follow the pin enables");
  mask_drop_a: assert property (
    request_mask |=> !irq_out)
    else $error("interrupt still shown after masking");
  wake_raise_a: assert property (
    (req_latched && !request_mask) |=> wake_out)
    else $error("unmasked request gave no wake");
  edge_wins_a: assert property (
    (ack_now && edge_det) |=> req_latched)
    else $error("acknowledge swallowed a new edge");
  edge_stay_a: assert property (
    (!sensitivity_select && req_latched && !ack_now) |=> req_latched)
    else $error("edge request cleared without acknowledge");
  level_need_ack_a: assert property (
    (sensitivity_select && req_latched && !ack_now && !ack_seen) |=> req_latched)
    else $error("level request cleared without acknowledge");
  edge_no_memo_a: assert property (
    !sensitivity_select |=> !ack_seen)
    else $error("acknowledge remembered in edge-only mode");

  edge_seen_c: cover property (!sensitivity_select ##1 edge_det ##1 ack_now);
  level_seen_c: cover property (sensitivity_select && req_latched && ack_now && low_any);
  break_seen_c: cover property (break_state_in && sw_ack_wr && !break_clear_permission_in);
  fetch_clear_c: cover property (fetch_ack && req_latched);
  level_wait_c: cover property (ack_seen && low_any);

endmodule // kwu_keypad_wake

`default_nettype wire

/* core/kwu_pkg.sv */
// Package for the keypad wake unit: register map, field positions,
// reset values and the pin control carrier.
// Assumes a 32-bit AXI4-Lite register bus and an eight-pin port.
package kwu_pkg;

  // Register byte addresses
  localparam logic [3:0] STATUS_CTRL_OFS = 4'h0;
  localparam logic [3:0] PIN_ENABLES_OFS = 4'h4;

  // Field positions in the status and control register
  localparam int MODE_BIT = 0;
  localparam int MASK_BIT = 1;
  localparam int ACK_BIT = 2;
  localparam int FLAG_BIT = 3;

  // Reset values
  localparam logic [7:0] PIN_ENABLES_RST = 8'h00;
  localparam logic MASK_RST = 1'b0;
  localparam logic MODE_RST = 1'b0;

  // Keypad vector, first byte of the pair
  localparam logic [15:0] VECTOR_ADDR = 16'hffe0;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control carried out to the port pad logic
  typedef struct packed {
    logic [7:0] pullup_en;
    logic [7:0] force_input;
  } kwu_pin_ctrl_t;

endpackage

/* test/kwu_keys_cpu.sv */
// Partner model: keypad switches on the port pins and the CPU vector fetch.
// Assumes the pad pullups follow the unit's pullup enables.
`timescale 1ns/1ps
`default_nettype none
module kwu_keys_cpu (
  input wire logic clk_in,
  input wire logic [7:0] press_in,
  input wire logic [7:0] drive_high_in,
  input wire logic [7:0] pullup_in,
  input wire logic fetch_en_in,
  input wire logic irq_in,
  output logic [7:0] pins_out,
  output logic fetch_out,
  output logic [15:0] addr_out
);
  logic [7:0] last = 8'h00;
  // A pin left floating toggles, so no level is handed out for free
  always @(posedge clk_in) begin
    last <= pins_out;
  end
  // Pressed key grounds the pin; otherwise port drive, pullup or float
  assign pins_out = ~press_in & (pullup_in | drive_high_in | ~last);
  // CPU fetches the keypad vector while the request is shown
  always @(posedge clk_in) begin
    fetch_out <= fetch_en_in & irq_in & ~fetch_out;
  end
  assign addr_out = fetch_out ? kwu_pkg::VECTOR_ADDR : ~kwu_pkg::VECTOR_ADDR;
endmodule // kwu_keys_cpu
`default_nettype wire

/* test/kwu_keypad_wake_test.sv */
// Bench for the keypad wake unit: registers, both modes, mask, break,
// vector fetch and reset. Assumes the kwu_keys_cpu partner model.
`timescale 1ns/1ps
`default_nettype none
module kwu_keypad_wake_test;
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [1:0] resp;
  } kwu_row_t;
  logic clk_in, rst_n_in, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, fetch, brk, bperm, irq, wake, fetch_en;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] pins, press, drive_high;
  logic [15:0] vaddr;
  kwu_pkg::kwu_pin_ctrl_t ctrl;
  int n_errors = 0;
  int samples_checked = 0;
  int guard = 0;
  int n_fetch = 0;
  kwu_row_t rows [4];

  kwu_keypad_wake i_kwu_keypad_wake (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .wake_pins_in(pins),
    .pin_ctrl_out(ctrl), .vector_fetch_in(fetch), .vector_addr_in(vaddr),
    .break_state_in(brk), .break_clear_permission_in(bperm), .irq_out(irq),
    .wake_out(wake));
  kwu_keys_cpu i_kwu_keys_cpu (.clk_in(clk_in), .press_in(press), .drive_high_in(drive_high),
    .pullup_in(ctrl.pullup_en), .fetch_en_in(fetch_en), .irq_in(irq),
    .pins_out(pins), .fetch_out(fetch), .addr_out(vaddr));

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) if (fetch) n_fetch++;

  task automatic tally_and_finish();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Every bus wait is bounded; running out ends the run as a failure
  task automatic step();
    @(posedge clk_in);
    guard++;
    if (guard > 100) begin
      n_errors++;
      tally_and_finish();
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    guard = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      step();
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do step(); while (!bvalid);
    chk(32'(bresp), 32'(er));
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    guard = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do step(); while (!arready);
    arvalid <= 1'b0;
    do step(); while (!rvalid);
    chk(rdata, ed);
    chk(32'(rresp), 32'(er));
  endtask
  task automatic ws(input logic [31:0] d);
    wr(kwu_pkg::STATUS_CTRL_OFS, d, kwu_pkg::RESP_OKAY);
  endtask
  task automatic rs(input logic [31:0] e);
    rd(kwu_pkg::STATUS_CTRL_OFS, e, kwu_pkg::RESP_OKAY);
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, brk, bperm, fetch_en} = '0;
    {awaddr, araddr, wdata, press, drive_high} = '0;
    wstrb = 4'hf;
    rst_n_in = 1'b0;
    rows = '{'{4'h0, 32'h7, 32'h3, kwu_pkg::RESP_OKAY},
      '{4'h8, 32'h1, 32'h0, kwu_pkg::RESP_SLVERR},
      '{4'h0, 32'h0, 32'h0, kwu_pkg::RESP_OKAY},
      '{4'h4, 32'hffffffa5, 32'ha5, kwu_pkg::RESP_OKAY}};
    wt(4);
    rst_n_in <= 1'b1;
    rs(32'h0);
    rd(kwu_pkg::PIN_ENABLES_OFS, 32'h0, kwu_pkg::RESP_OKAY);
    chk(32'(ctrl), 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata, rows[i].resp);
      rd(rows[i].addr, rows[i].rdata, rows[i].resp);
    end
    chk(32'(ctrl), 32'ha5a5);
    // Masked start-up so the pullup charge cannot leave a false request
    ws(32'h2);
    wr(kwu_pkg::PIN_ENABLES_OFS, 32'hff, kwu_pkg::RESP_OKAY);
    wt(8);
    ws(32'h6);
    ws(32'h0);
    rs(32'h0);
    // Edge-only mode
    press <= 8'h01;
    wt(8);
    chk(32'({irq, wake}), 32'h3);
    rs(32'h8);
    ws(32'h4);
    rs(32'h0);
    press <= 8'h03;
    wt(8);
    rs(32'h0);
    press <= 8'h00;
    wt(8);
    press <= 8'h04;
    wt(8);
    rs(32'h8);
    ws(32'h2);
    wt(2);
    chk(32'(irq), 32'h0);
    rs(32'ha);
    brk <= 1'b1;
    ws(32'h6);
    rs(32'ha);
    bperm <= 1'b1;
    ws(32'h6);
    {brk, bperm, press} <= '0;
    wt(8);
    rs(32'h2);
    // Edge-and-level mode, both orders of acknowledge and release
    ws(32'h1);
    press <= 8'h08;
    wt(8);
    ws(32'h5);
    wt(4);
    rs(32'h9);
    press <= 8'h00;
    wt(8);
    rs(32'h1);
    press <= 8'h10;
    wt(8);
    press <= 8'h00;
    wt(8);
    rs(32'h9);
    ws(32'h5);
    rs(32'h1);
    // Disabled pin is ignored
    wr(kwu_pkg::PIN_ENABLES_OFS, 32'hfe, kwu_pkg::RESP_OKAY);
    wt(8);
    press <= 8'h01;
    wt(8);
    rs(32'h1);
    // CPU vector fetch acknowledges
    ws(32'h0);
    fetch_en <= 1'b1;
    press <= 8'h20;
    wt(12);
    rs(32'h0);
    chk(32'(n_fetch > 0), 32'h1);
    fetch_en <= 1'b0;
    // Reset in mid-run with a pin held low
    ws(32'h1);
    press <= 8'h00;
    wt(4);
    press <= 8'h40;
    wt(8);
    rs(32'h9);
    rst_n_in <= 1'b0;
    wt(2);
    rst_n_in <= 1'b1;
    rs(32'h0);
    chk(32'(irq), 32'h0);
    rd(kwu_pkg::PIN_ENABLES_OFS, 32'h0, kwu_pkg::RESP_OKAY);
    // Pins driven high as outputs before enabling: no false request
    {press, drive_high} <= {8'h00, 8'hff};
    wt(4);
    wr(kwu_pkg::PIN_ENABLES_OFS, 32'hff, kwu_pkg::RESP_OKAY);
    drive_high <= 8'h00;
    wt(8);
    rs(32'h0);
    chk(32'(irq), 32'h0);
    tally_and_finish();
  end
endmodule // kwu_keypad_wake_test
`default_nettype wire
